// ==== port_expander_pkg.sv ====
package port_expander_pkg;

  // Fixed upper four bits of the seven-bit target address
  localparam logic [3:0] ADDR_UPPER_BITS = 4'h4;
  // Width of one port group
  localparam int unsigned PORT_WIDTH = 8;
  // Output latch value after reset: all ports released high
  localparam logic [7:0] PORT_OUT_RESET = 8'hff;
  // Bits per byte before the acknowledge slot
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Synchronised bus line levels and their edges
  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } bus_sample_t;

endpackage

// ==== bus_sampler.sv ====
`timescale 1ns/1ns
// Two-stage synchroniser for the bus lines, plus edge and condition detection
module bus_sampler
(
  input  wire logic                        clk_i,
  input  wire logic                        rst_b_i,
  input  wire logic                        scl_i,
  input  wire logic                        sda_i,
  output port_expander_pkg::bus_sample_t   bus_o
);

  logic [1:0] scl_sync;   // Synchroniser chain for the clock line
  logic [1:0] sda_sync;   // Synchroniser chain for the data line
  logic       scl_prev;   // Previous stable clock level
  logic       sda_prev;   // Previous stable data level

  // Synchronise both lines; idle high after reset
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  // Decode edges and start/stop from the stable stage only
  always_comb
  begin
    bus_o.scl      = scl_sync[1];
    bus_o.sda      = sda_sync[1];
    bus_o.scl_rise = scl_sync[1] & ~scl_prev;
    bus_o.scl_fall = ~scl_sync[1] & scl_prev;
    bus_o.start    = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
    bus_o.stop     = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];
  end

endmodule

// ==== port_expander.sv ====
`timescale 1ns/1ns
module port_expander
#(
  parameter int unsigned WIDTH = port_expander_pkg::PORT_WIDTH
)
(
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             scl_i,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe_b_o,
  input  wire logic [WIDTH-1:0] expander_port_pins_i,
  output logic      [WIDTH-1:0] expander_port_pins_o,
  output logic      [WIDTH-1:0] expander_port_pins_oe_b_o,
  input  wire logic             addr_select_bit0_i,
  input  wire logic             addr_select_bit1_i,
  input  wire logic             addr_select_bit2_i,
  output logic                  alert_b_o,
  output logic                  alert_oe_b_o
);

  typedef enum logic [2:0] {
    IDLE,
    ADDR,
    ADDR_ACK,
    WR_DATA,
    WR_ACK,
    RD_DATA,
    RD_ACK
  } state_t;

  port_expander_pkg::bus_sample_t bus;     // Synchronised bus view
  state_t                         state;   // Transaction state
  logic [3:0]                     bit_cnt; // Bits taken in current byte
  logic [7:0]                     shift;   // Receive / transmit shift register
  logic [WIDTH-1:0]               pin_sync0; // Port pin synchroniser stage one
  logic [WIDTH-1:0]               pin_sync1; // Port pin synchroniser stage two
  logic [WIDTH-1:0]               reference; // Reference for change detection
  logic                           alert;     // Change alert pending
  logic                           hold_off;  // Alert held released until stop
  logic                           ack_drive; // Device pulls data low in ack slots and for zero read bits
  logic [6:0]                     own_addr;  // Own seven-bit address
  logic [2:0]                     sel_sync0; // Address select synchroniser stage one
  logic [2:0]                     sel_sync1; // Address select synchroniser stage two

  // Edge and condition detector for the bus
  bus_sampler u_bus_sampler
  (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .bus_o   (bus)
  );

  // Own address built from fixed part and synchronised select pins
  assign own_addr = {port_expander_pkg::ADDR_UPPER_BITS, sel_sync1};

  // Port and address select pins pass two flip-flops before use
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      pin_sync0 <= '1;
      pin_sync1 <= '1;
      sel_sync0 <= '0;
      sel_sync1 <= '0;
    end
    else
    begin
      pin_sync0 <= expander_port_pins_i;
      pin_sync1 <= pin_sync0;
      sel_sync0 <= {addr_select_bit2_i, addr_select_bit1_i, addr_select_bit0_i};
      sel_sync1 <= sel_sync0;
    end
  end

  // Transaction sequencer: received bits shift on rising clock, read bits shift out and slots change on falling; a read nack ends on rising
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      state   <= IDLE;
      bit_cnt <= 4'h0;
      shift   <= 8'hff;
    end
    else if (bus.stop)
    begin
      state <= IDLE;
    end
    else if (bus.start)
    begin
      // Start and repeated start both restart address reception
      state   <= ADDR;
      bit_cnt <= 4'h0;
    end
    else
    begin
      case (state)
        IDLE:
        begin
          bit_cnt <= 4'h0;
        end
        ADDR, WR_DATA:
        begin
          if (bus.scl_rise)
          begin
            shift   <= {shift[6:0], bus.sda};
            bit_cnt <= bit_cnt + 4'h1;
          end
          else if (bus.scl_fall && bit_cnt == port_expander_pkg::BITS_PER_BYTE)
          begin
            if (state == WR_DATA)
            begin
              state <= WR_ACK;
            end
            else if (shift[7:1] == own_addr)
            begin
              state <= ADDR_ACK;
            end
            else
            begin
              state <= IDLE;
            end
          end
        end
        ADDR_ACK, WR_ACK:
        begin
          bit_cnt <= 4'h0;
          if (bus.scl_fall)
          begin
            if (state == ADDR_ACK && shift[0])
            begin
              // Load pins sampled during the acknowledge
              shift <= pin_sync1;
              state <= RD_DATA;
            end
            else
            begin
              state <= WR_DATA;
            end
          end
        end
        RD_DATA:
        begin
          if (bus.scl_fall)
          begin
            shift   <= {shift[6:0], shift[7]};
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == port_expander_pkg::BITS_PER_BYTE - 4'h1)
            begin
              state <= RD_ACK;
            end
          end
        end
        RD_ACK:
        begin
          bit_cnt <= 4'h0;
          if (bus.scl_rise && bus.sda)
          begin
            state <= IDLE;
          end
          else if (bus.scl_fall)
          begin
            // Repeat fresh pin data on every further byte
            shift <= pin_sync1;
            state <= RD_DATA;
          end
        end
        default:
        begin
          state <= IDLE;
        end
      endcase
    end
  end

  // Data line drive: acknowledge in address and write ack slots, shift out during reads
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      ack_drive <= 1'b0;
    end
    else
    begin
      ack_drive <= (state == ADDR_ACK || state == WR_ACK) ||
                   (state == RD_DATA && !shift[7]);
    end
  end

  // Open-drain data line: only ever pulls low
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      sda_o      <= 1'b0;
      sda_oe_b_o <= 1'b1;
    end
    else
    begin
      sda_o      <= 1'b0;
      sda_oe_b_o <= ~ack_drive;
    end
  end

  // Output latch updated at each write-byte acknowledge
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      expander_port_pins_o      <= '0;
      expander_port_pins_oe_b_o <= port_expander_pkg::PORT_OUT_RESET;
    end
    else if (state == WR_DATA && bus.scl_fall && bit_cnt == port_expander_pkg::BITS_PER_BYTE)
    begin
      // Zero pulls the port low, one releases it
      expander_port_pins_oe_b_o <= shift;
    end
  end

  // Change reference and alert state
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      reference <= '1;
      alert     <= 1'b0;
      hold_off  <= 1'b0;
    end
    else if (state == RD_ACK && bus.scl_rise)
    begin
      // Data just sent becomes the reference; alert released until stop
      reference <= shift;
      alert     <= 1'b0;
      hold_off  <= 1'b1;
    end
    else if (state == WR_ACK && bus.scl_fall)
    begin
      reference <= pin_sync1;
      alert     <= 1'b0;
    end
    else
    begin
      if (bus.stop)
      begin
        hold_off <= 1'b0;
      end
      if (pin_sync1 != reference)
      begin
        alert <= 1'b1;
      end
      else if (!hold_off)
      begin
        // Pins back to reference clear the alert
        alert <= 1'b0;
      end
    end
  end

  // Active-low open-drain alert output
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      alert_b_o    <= 1'b0;
      alert_oe_b_o <= 1'b1;
    end
    else
    begin
      alert_b_o    <= 1'b0;
      alert_oe_b_o <= ~(alert & ~hold_off);
    end
  end

endmodule

// ==== port_expander_assertions.sv ====
`timescale 1ns/1ns
// Boundary checks on the expander: drive polarity, reset state, bus timing, alert
module port_expander_assertions
#(
  parameter int unsigned WIDTH = 8
)
(
  input wire logic             clk_i,
  input wire logic             rst_b_i,
  input wire logic             scl_i,
  input wire logic             sda_i,
  input wire logic             sda_o,
  input wire logic             sda_oe_b_o,
  input wire logic [WIDTH-1:0] expander_port_pins_i,
  input wire logic [WIDTH-1:0] expander_port_pins_o,
  input wire logic [WIDTH-1:0] expander_port_pins_oe_b_o,
  input wire logic             alert_b_o,
  input wire logic             alert_oe_b_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // Leaving reset, every drive is released
  property p_rst_port;
    $rose(rst_b_i) |-> &expander_port_pins_oe_b_o;
  endproperty
  property p_rst_flag;
    $rose(rst_b_i) |-> alert_oe_b_o && sda_oe_b_o;
  endproperty
  // Open-drain pins only ever pull low
  property p_sda_low;
    !sda_oe_b_o |-> !sda_o;
  endproperty
  property p_port_low;
    (expander_port_pins_o & ~expander_port_pins_oe_b_o) == '0;
  endproperty
  property p_alert_low;
    !alert_oe_b_o |-> !alert_b_o;
  endproperty
  // Data and port drive move only well inside the bus clock low phase
  property p_sda_move;
    $changed(sda_oe_b_o) |-> !scl_i && !$past(scl_i, 2);
  endproperty
  property p_port_move;
    $changed(expander_port_pins_oe_b_o) |-> !scl_i && !$past(scl_i, 2);
  endproperty
  // A pin edge on an idle bus raises the alert within a few cycles
  property p_alert_edge;
    $changed(expander_port_pins_i) && alert_oe_b_o && scl_i && sda_i
      |-> ##[1:6] !alert_oe_b_o;
  endproperty
  a_rst_port: assert property (p_rst_port) else $error("ports held after reset");
  a_rst_flag: assert property (p_rst_flag) else $error("alert or data driven after reset");
  a_sda_low: assert property (p_sda_low) else $error("data line driven high");
  a_port_low: assert property (p_port_low) else $error("port driven high");
  a_alert_low: assert property (p_alert_low) else $error("alert driven high");
  a_sda_move: assert property (p_sda_move) else $error("data moved near clock high");
  a_port_move: assert property (p_port_move) else $error("port moved near clock high");
  a_alert_edge: assert property (p_alert_edge) else $error("pin edge missed");
  c_alert_set: cover property ($fell(alert_oe_b_o));
  c_alert_clr: cover property ($rose(alert_oe_b_o));
  c_port_upd: cover property ($changed(expander_port_pins_oe_b_o));
endmodule
bind port_expander port_expander_assertions #(.WIDTH(WIDTH)) i_chk (.clk_i, .rst_b_i, .scl_i,
  .sda_i, .sda_o, .sda_oe_b_o, .expander_port_pins_i, .expander_port_pins_o,
  .expander_port_pins_oe_b_o, .alert_b_o, .alert_oe_b_o);

// ==== bus_master_model.sv ====
`timescale 1ns/1ns
// Two-wire bus master; clock stands high between frames, 320 ns bit time
module bus_master_model
(
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Wait a number of system clocks
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Data falls while clock is high
  task automatic start();
    tick(4);
    sda_o <= 1'b0;
    tick(4);
    scl_o <= 1'b0;
  endtask
  // Data rises while clock is high
  task automatic stop();
    tick(3);
    sda_o <= 1'b0;
    tick(3);
    scl_o <= 1'b1;
    tick(4);
    sda_o <= 1'b1;
    tick(4);
  endtask
  // One bit: six clocks low, two high, line read at the end of the high phase
  task automatic bit_io(input logic b, output logic r);
    tick(3);
    sda_o <= b;
    tick(3);
    scl_o <= 1'b1;
    tick(2);
    r = sda_i;
    scl_o <= 1'b0;
  endtask
  // Byte MSB first then acknowledge; a one sent releases the line
  task automatic xbyte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                       output logic ack_out);
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_in, ack_out);
  endtask
endmodule

// ==== tb.sv ====
`timescale 1ns/1ns
module tb;
  logic       clk_i;        // System clock
  logic       rst_b_i;      // Reset, active low
  logic       scl_i;        // Bus clock from the master
  logic       m_sda;        // Master pull on data
  wire        sda_i;        // Data wire with pull-up
  logic       sda_o;        // Device data value
  logic       sda_oe_b_o;   // Device data enable
  logic [7:0] pins;         // Port pin levels
  logic [7:0] drive_b;      // Port drive enables
  logic [2:0] sel;          // Address select pins
  logic       alert_oe_b_o; // Alert enable
  logic [7:0] rx;           // Byte read back
  logic       ack;          // Acknowledge seen
  int         fails = 0;
  int         n_compared = 0;
  assign sda_i = m_sda & (sda_oe_b_o | sda_o);
  port_expander i_dut (.clk_i, .rst_b_i, .scl_i, .sda_i, .sda_o, .sda_oe_b_o,
    .expander_port_pins_i(pins), .expander_port_pins_o(), .expander_port_pins_oe_b_o(drive_b),
    .addr_select_bit0_i(sel[0]), .addr_select_bit1_i(sel[1]), .addr_select_bit2_i(sel[2]),
    .alert_b_o(), .alert_oe_b_o);
  bus_master_model i_m (.clk_i, .sda_i, .scl_o(scl_i), .sda_o(m_sda));
  // 25 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Cut a hang short
  initial
  begin
    #1000000;
    fails++;
    tally_and_finish();
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Own address with direction bit
  function automatic logic [7:0] adr(input logic rd);
    return {port_expander_pkg::ADDR_UPPER_BITS, sel, rd};
  endfunction
  // Change pins on an idle bus, then let the alert settle
  task automatic set_pins(input logic [7:0] v);
    pins <= v;
    i_m.tick(8);
  endtask
  // Every select setting, one write each
  task automatic t_write_sel();
    for (int s = 0; s < 8; s++)
    begin
      sel <= s[2:0];
      i_m.start();
      i_m.xbyte(adr(1'b0), 1'b1, rx, ack);
      chk(ack, 1'b0, "address ack");
      i_m.xbyte(8'h5a ^ 8'(s), 1'b1, rx, ack);
      chk(ack, 1'b0, "data ack");
      chk(drive_b, 8'h5a ^ 8'(s), "port drive");
      i_m.stop();
    end
  endtask
  // Alert raised, then cleared by a multi-byte write
  task automatic t_multi_write();
    logic [7:0] ds [3] = '{8'h00, 8'hc3, 8'hff};
    set_pins(8'h3c);
    chk(alert_oe_b_o, 1'b0, "alert on edge");
    i_m.start();
    i_m.xbyte(adr(1'b0), 1'b1, rx, ack);
    for (int i = 0; i < 3; i++)
    begin
      i_m.xbyte(ds[i], 1'b1, rx, ack);
      i_m.tick(6);
      chk(ack, 1'b0, "data ack");
      chk(drive_b, ds[i], "port update");
      chk(alert_oe_b_o, 1'b1, "write clears alert");
    end
    i_m.stop();
  endtask
  // Three-byte read, then a one-byte read
  task automatic t_read();
    set_pins(8'hc3);
    i_m.start();
    i_m.xbyte(adr(1'b1), 1'b1, rx, ack);
    chk(ack, 1'b0, "read address ack");
    for (int i = 0; i < 3; i++)
    begin
      i_m.xbyte(8'hff, i == 2, rx, ack);
      i_m.tick(4);
      chk(rx, 8'hc3, "read data");
      chk(alert_oe_b_o, 1'b1, "alert released");
    end
    i_m.stop();
    set_pins(8'h96);
    i_m.start();
    i_m.xbyte(adr(1'b1), 1'b1, rx, ack);
    i_m.xbyte(8'hff, 1'b1, rx, ack);
    chk(rx, 8'h96, "single read");
    i_m.stop();
    i_m.tick(4);
    chk(alert_oe_b_o, 1'b1, "reference taken");
    set_pins(8'h69);
    chk(alert_oe_b_o, 1'b0, "edge after read");
  endtask
  // Foreign address is ignored
  task automatic t_foreign();
    i_m.start();
    i_m.xbyte({port_expander_pkg::ADDR_UPPER_BITS ^ 4'h1, sel, 1'b0}, 1'b1, rx, ack);
    chk(ack, 1'b1, "no address ack");
    i_m.xbyte(8'h00, 1'b1, rx, ack);
    chk(ack, 1'b1, "no data ack");
    i_m.stop();
    chk(drive_b, 8'hff, "ports untouched");
  endtask
  // Mid-run reset returns written ports and alert to their idle state
  task automatic t_reset();
    i_m.start();
    i_m.xbyte(adr(1'b0), 1'b1, rx, ack);
    i_m.xbyte(8'h0f, 1'b1, rx, ack);
    i_m.stop();
    chk(drive_b, 8'h0f, "port before reset");
    set_pins(8'hff);
    rst_b_i <= 1'b0;
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(drive_b, 8'hff, "ports after reset");
    chk(alert_oe_b_o, 1'b1, "alert after reset");
  endtask
  initial
  begin
    rst_b_i = 1'b0;
    pins = 8'hff;
    sel = 3'h0;
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(drive_b, 8'hff, "reset ports");
    chk(alert_oe_b_o, 1'b1, "reset alert");
    t_write_sel();
    t_multi_write();
    t_read();
    t_foreign();
    t_reset();
    tally_and_finish();
  end
endmodule
